//--- verilog/csc_pkg.sv
`default_nettype none
package csc_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int HS_STAB_NS = 2000;
    localparam int HS_STAB_CYC = (HS_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SWITCH_CYC = 2;
    localparam int SETTLE_BASE = 8;
    localparam int SETTLE_SEL_MAX = 4;

    // Register byte offsets
    localparam logic [11:0] MAIN_MODE_OFF = 12'h000;
    localparam logic [11:0] INT_MODE_OFF = 12'h004;
    localparam logic [11:0] PIN_CTRL_OFF = 12'h008;
    localparam logic [11:0] MAIN_OSC_OFF = 12'h00C;
    localparam logic [11:0] SETTLE_SEL_OFF = 12'h010;
    localparam logic [11:0] SETTLE_CNT_OFF = 12'h014;

    // Field positions
    localparam int MAIN_SEL_BIT = 0;
    localparam int MAIN_STATUS_BIT = 1;
    localparam int MAIN_HSEN_BIT = 2;
    localparam int INT_HSSTOP_BIT = 0;
    localparam int INT_LSSTOP_BIT = 1;
    localparam int INT_STABLE_BIT = 7;
    localparam int OSC_PINMODE_BIT = 6;
    localparam int OSC_EXTSEL_BIT = 7;
    localparam int MAIN_OSC_STOP_BIT = 7;
    localparam int SETTLE_SEL_W = 3;
    localparam int SETTLE_CNT_W = 13;

    localparam logic [1:0] PERIPH_INT = 2'h0;
    localparam logic [1:0] PERIPH_X1 = 2'h1;
    localparam logic [1:0] PERIPH_EXT = 2'h2;

    typedef enum logic [3:0] {
        CSC_RUN = 4'b0001,
        CSC_HALT = 4'b0010,
        CSC_STOP = 4'b0100,
        CSC_WAKE = 4'b1000
    } csc_mode_e;

    typedef struct packed {
        logic hsEnSel;
        logic hsEnLocked;
        logic mainSel;
        logic hsStop;
        logic lsStop;
        logic extSel;
        logic pinMode;
        logic mainStop;
        logic [SETTLE_SEL_W-1:0] settleSel;
    } csc_ctrl_s;

    localparam csc_ctrl_s CTRL_RST = '{hsEnSel: 1'b0, hsEnLocked: 1'b0, mainSel: 1'b0,
        hsStop: 1'b0, lsStop: 1'b0, extSel: 1'b0, pinMode: 1'b0, mainStop: 1'b1,
        settleSel: 3'h4};

    typedef struct packed {
        logic hsOscEn;
        logic x1OscEn;
        logic extClkEn;
        logic lsOscEn;
        logic wdtClkEn;
        logic cpuClkHigh;
        logic [1:0] periphSel;
        logic stopMode;
        logic haltMode;
    } csc_out_s;

    localparam csc_out_s OUT_RST = '{hsOscEn: 1'b1, x1OscEn: 1'b0, extClkEn: 1'b0,
        lsOscEn: 1'b1, wdtClkEn: 1'b0, cpuClkHigh: 1'b0, periphSel: 2'h0,
        stopMode: 1'b0, haltMode: 1'b0};
endpackage : csc_pkg
`default_nettype wire

//--- verilog/csc_top.sv
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: STOP instruction halts internal high-speed oscillator
// RULE2: Stop bit one stops internal high-speed clock
// RULE3: Status reads zero internal, one high-speed
// RULE4: Software checks status before stopping internal
// RULE5: Software halts unusable peripherals before STOP
// RULE6: Software sets settle time before STOP
// RULE7: Software returns to internal clock after STOP
// RULE8: Low-speed clock never feeds the CPU
// RULE9: Option decides if low-speed is stoppable
// RULE10: Low-speed runs after reset, clocks watchdog
// RULE11: Low-speed stop bit stops and restarts it
// RULE12: Enable and select bits pick CPU/peripheral sources
// RULE13: Ext select bit7, pin mode bit6
// RULE14: Main stop bit7; enable bit2, select bit0
// RULE15: Software X1 switch sequence with settle check
// RULE16: Software external clock sequence, no check
// RULE17: Software return sequence waits for stable
// RULE18: After reset CPU runs on internal clock
// RULE19: HALT entered from either CPU clock
// RULE20: Stable flag bit7, internal stop bit0
// RULE21: High-speed enable accepts only one change
// RULE22: Status flips only after switchover completes
module csc_top
    import csc_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stopExec,
    input wire logic haltExec,
    input wire logic wakeReq,
    input wire logic lsStoppableOpt,
    input wire logic wdtEnableOpt,
    output logic hsOscEn,
    output logic x1OscEn,
    output logic extClkEn,
    output logic lsOscEn,
    output logic wdtClkEn,
    output logic cpuClkHigh,
    output logic [1:0] periphSel,
    output logic stopMode,
    output logic haltMode
);

    function automatic logic csc_hit(input logic [11:0] a);
        csc_hit = (a == MAIN_MODE_OFF) || (a == INT_MODE_OFF) || (a == PIN_CTRL_OFF)
            || (a == MAIN_OSC_OFF) || (a == SETTLE_SEL_OFF) || (a == SETTLE_CNT_OFF);
    endfunction : csc_hit

    function automatic logic [SETTLE_CNT_W-1:0] csc_settle_limit(
        input logic [SETTLE_SEL_W-1:0] s);
        logic [SETTLE_SEL_W-1:0] c;
        c = (s > SETTLE_SEL_W'(SETTLE_SEL_MAX)) ? SETTLE_SEL_W'(SETTLE_SEL_MAX) : s;
        csc_settle_limit = SETTLE_CNT_W'(1) << (SETTLE_BASE + int'(c));
    endfunction : csc_settle_limit

    csc_ctrl_s ctrl_q, ctrl_d;
    csc_out_s out_q, out_d;
    csc_mode_e mode_q, mode_d;
    logic cpuStatus_q, cpuStatus_d;
    logic [1:0] swCnt_q, swCnt_d;
    logic [7:0] stabCnt_q, stabCnt_d;
    logic [SETTLE_CNT_W-1:0] settleCnt_q, settleCnt_d;
    logic [31:0] prdata_q, prdata_d;
    logic [1:0] lsOptSync_q, wdtOptSync_q;
    logic lsStopOk, wdtOk;
    logic wr, hsIntRun, x1Run, extRun, hsSysRun, stable, settleDone, wantHigh, destRun;

    // Straps come from pins: two flops before use
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            lsOptSync_q <= 2'h0;
            wdtOptSync_q <= 2'h0;
        end else begin
            lsOptSync_q <= {lsOptSync_q[0], lsStoppableOpt};
            wdtOptSync_q <= {wdtOptSync_q[0], wdtEnableOpt};
        end
    end
    assign lsStopOk = lsOptSync_q[1];
    assign wdtOk = wdtOptSync_q[1];

    // Register writes
    assign wr = psel && penable && pwrite;
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr) begin
            case (paddr)
                MAIN_MODE_OFF: begin
                    if (!ctrl_q.hsEnLocked && (pwdata[MAIN_HSEN_BIT] != ctrl_q.hsEnSel)) begin
                        ctrl_d.hsEnSel = pwdata[MAIN_HSEN_BIT]; // RULE21 RULE14
                        ctrl_d.hsEnLocked = 1'b1; // RULE21
                    end
                    ctrl_d.mainSel = pwdata[MAIN_SEL_BIT]; // RULE14
                end
                INT_MODE_OFF: begin
                    ctrl_d.hsStop = pwdata[INT_HSSTOP_BIT]; // RULE20
                    ctrl_d.lsStop = pwdata[INT_LSSTOP_BIT];
                end
                PIN_CTRL_OFF: begin
                    ctrl_d.extSel = pwdata[OSC_EXTSEL_BIT]; // RULE13
                    ctrl_d.pinMode = pwdata[OSC_PINMODE_BIT]; // RULE13
                end
                MAIN_OSC_OFF: ctrl_d.mainStop = pwdata[MAIN_OSC_STOP_BIT]; // RULE14
                SETTLE_SEL_OFF: ctrl_d.settleSel = pwdata[SETTLE_SEL_W-1:0];
                default: ;
            endcase
        end
    end

    // Oscillator run conditions; STOP kills both main sources
    assign hsIntRun = !ctrl_q.hsStop && (mode_q != CSC_STOP); // RULE1 RULE2
    assign x1Run = !ctrl_q.mainStop && ctrl_q.pinMode && !ctrl_q.extSel && (mode_q != CSC_STOP);
    assign extRun = !ctrl_q.mainStop && ctrl_q.pinMode && ctrl_q.extSel && (mode_q != CSC_STOP);
    assign stable = (stabCnt_q == 8'(HS_STAB_CYC));
    assign settleDone = (settleCnt_q >= csc_settle_limit(ctrl_q.settleSel));
    assign hsSysRun = (x1Run && settleDone) || extRun;

    always_comb begin
        stabCnt_d = 8'h00;
        if (hsIntRun) begin
            stabCnt_d = stable ? stabCnt_q : stabCnt_q + 8'h01;
        end
        settleCnt_d = {SETTLE_CNT_W{1'b0}};
        if (x1Run) begin
            settleCnt_d = (&settleCnt_q) ? settleCnt_q : settleCnt_q + SETTLE_CNT_W'(1);
        end
    end

    // Switchover waits for the target clock, then a few cycles, before status moves
    assign wantHigh = ctrl_q.mainSel && ctrl_q.hsEnSel; // RULE12
    assign destRun = wantHigh ? hsSysRun : hsIntRun;
    always_comb begin
        cpuStatus_d = cpuStatus_q;
        swCnt_d = 2'h0;
        if ((wantHigh != cpuStatus_q) && destRun && (mode_q == CSC_RUN)) begin
            if (swCnt_q == 2'(SWITCH_CYC - 1)) begin
                cpuStatus_d = wantHigh; // RULE22 RULE3
            end else begin
                swCnt_d = swCnt_q + 2'h1;
            end
        end
    end

    // Standby modes
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            CSC_RUN: begin
                if (stopExec) begin
                    mode_d = CSC_STOP; // RULE1
                end else if (haltExec) begin
                    mode_d = CSC_HALT; // RULE19
                end
            end
            CSC_HALT: if (wakeReq) mode_d = CSC_RUN;
            CSC_STOP: if (wakeReq) mode_d = cpuStatus_q ? CSC_WAKE : CSC_RUN;
            // X1 must settle again before the CPU resumes on it
            CSC_WAKE: if (hsSysRun || !cpuStatus_q) mode_d = CSC_RUN;
            default: mode_d = CSC_RUN;
        endcase
    end

    // Clock steering outputs, registered
    always_comb begin
        out_d.hsOscEn = hsIntRun; // RULE1 RULE2
        out_d.x1OscEn = x1Run || ((mode_q == CSC_WAKE) && !ctrl_q.extSel);
        out_d.extClkEn = extRun;
        out_d.lsOscEn = !(lsStopOk && ctrl_q.lsStop); // RULE9 RULE11 RULE10
        out_d.wdtClkEn = out_d.lsOscEn && wdtOk; // RULE10
        // Only internal or high-speed system clock can reach the CPU
        out_d.cpuClkHigh = cpuStatus_q; // RULE8 RULE18
        out_d.periphSel = !ctrl_q.hsEnSel ? PERIPH_INT
            : (ctrl_q.extSel ? PERIPH_EXT : PERIPH_X1); // RULE12
        out_d.stopMode = (mode_q == CSC_STOP);
        out_d.haltMode = (mode_q == CSC_HALT); // RULE19
    end

    // APB read data captured in setup phase, zero wait states
    always_comb begin
        prdata_d = prdata_q;
        if (psel && !penable && !pwrite) begin
            prdata_d = 32'h0000_0000;
            case (paddr)
                MAIN_MODE_OFF: begin
                    prdata_d[MAIN_HSEN_BIT] = ctrl_q.hsEnSel;
                    prdata_d[MAIN_STATUS_BIT] = cpuStatus_q; // RULE3
                    prdata_d[MAIN_SEL_BIT] = ctrl_q.mainSel;
                end
                INT_MODE_OFF: begin
                    prdata_d[INT_STABLE_BIT] = stable; // RULE20
                    prdata_d[INT_LSSTOP_BIT] = ctrl_q.lsStop;
                    prdata_d[INT_HSSTOP_BIT] = ctrl_q.hsStop;
                end
                PIN_CTRL_OFF: begin
                    prdata_d[OSC_EXTSEL_BIT] = ctrl_q.extSel;
                    prdata_d[OSC_PINMODE_BIT] = ctrl_q.pinMode;
                end
                MAIN_OSC_OFF: prdata_d[MAIN_OSC_STOP_BIT] = ctrl_q.mainStop;
                SETTLE_SEL_OFF: prdata_d[SETTLE_SEL_W-1:0] = ctrl_q.settleSel;
                SETTLE_CNT_OFF: prdata_d[SETTLE_CNT_W-1:0] = settleCnt_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RST;
            out_q <= OUT_RST; // RULE18 RULE10
            mode_q <= CSC_RUN;
            cpuStatus_q <= 1'b0; // RULE18
            swCnt_q <= 2'h0;
            stabCnt_q <= 8'h00;
            settleCnt_q <= {SETTLE_CNT_W{1'b0}};
            prdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            out_q <= out_d;
            mode_q <= mode_d;
            cpuStatus_q <= cpuStatus_d;
            swCnt_q <= swCnt_d;
            stabCnt_q <= stabCnt_d;
            settleCnt_q <= settleCnt_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !csc_hit(paddr);
    assign hsOscEn = out_q.hsOscEn;
    assign x1OscEn = out_q.x1OscEn;
    assign extClkEn = out_q.extClkEn;
    assign lsOscEn = out_q.lsOscEn;
    assign wdtClkEn = out_q.wdtClkEn;
    assign cpuClkHigh = out_q.cpuClkHigh;
    assign periphSel = out_q.periphSel;
    assign stopMode = out_q.stopMode;
    assign haltMode = out_q.haltMode;

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    chk_stop_hs_off: assert property ( // RULE1
        (mode_q == CSC_STOP) |=> (!hsOscEn && stopMode))
        else $error("internal oscillator running in STOP");
    chk_hs_stop_bit: assert property ( // RULE2
        ctrl_q.hsStop |=> !hsOscEn)
        else $error("internal oscillator not stopped by stop bit");
    chk_status_read: assert property ( // RULE3
        (psel && !penable && !pwrite && paddr == MAIN_MODE_OFF)
        |=> (prdata[MAIN_STATUS_BIT] == $past(cpuStatus_q)))
        else $error("status bit read mismatch");
    chk_cpu_not_ls: assert property ( // RULE8
        cpuClkHigh |-> ctrl_q.hsEnSel)
        else $error("CPU on unexpected clock");
    chk_ls_unstoppable: assert property ( // RULE9
        !lsStopOk |=> lsOscEn)
        else $error("low-speed stopped although not stoppable");
    chk_ls_stop_bit: assert property ( // RULE11
        (lsStopOk && ctrl_q.lsStop) |=> !lsOscEn ##0 !wdtClkEn)
        else $error("low-speed not stopped");
    chk_periph_ext: assert property ( // RULE12
        (ctrl_q.hsEnSel && ctrl_q.extSel) |=> (periphSel == PERIPH_EXT))
        else $error("peripheral clock not external");
    chk_reset_internal: assert property ( // RULE18
        $rose(nrst) |-> (!cpuClkHigh && hsOscEn && lsOscEn)[*3])
        else $error("not on internal clock after reset");
    chk_halt_entry: assert property ( // RULE19
        (mode_q == CSC_RUN && haltExec && !stopExec) |=> ##1 haltMode)
        else $error("HALT not entered");
    chk_hsen_once: assert property ( // RULE21
        ctrl_q.hsEnLocked |=> $stable(ctrl_q.hsEnSel))
        else $error("enable select changed twice");
    chk_switch_delay: assert property ( // RULE22
        $changed(cpuStatus_q) |-> ($past(swCnt_q) == 2'(SWITCH_CYC - 1)) && $past(destRun))
        else $error("status changed before switchover");
    // Watchdog must keep its clock whenever the strap enables it and the low-speed clock is not stopped
    chk_wdt_clock: assert property ( // RULE10
        (wdtOk && !(lsStopOk && ctrl_q.lsStop)) |=> wdtClkEn)
        else $error("watchdog clock missing");
    chk_periph_int: assert property ( // RULE12
        !ctrl_q.hsEnSel |=> (periphSel == PERIPH_INT))
        else $error("peripheral clock not internal");
    chk_stable_clear: assert property ( // RULE20
        ctrl_q.hsStop |=> !stable)
        else $error("stable flag set while oscillator stopped");

    cov_to_high: cover property ($rose(cpuStatus_q));
    cov_back_internal: cover property ($fell(cpuStatus_q));
    cov_stop_wake: cover property ((mode_q == CSC_STOP) ##1 (mode_q == CSC_WAKE));
    cov_halt: cover property ((mode_q == CSC_HALT) ##1 (mode_q == CSC_RUN));

endmodule : csc_top
`default_nettype wire

//--- bench/csc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module csc_top_bench;
    import csc_pkg::*;
    logic mclk = 1'b0;
    logic nrst, psel, penable, pwrite, stopExec, haltExec, wakeReq, lsOpt, wdtOpt;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic pready, pslverr, hsOscEn, x1OscEn, extClkEn, lsOscEn, wdtClkEn, cpuClkHigh;
    logic stopMode, haltMode, ev;
    logic [1:0] periphSel;
    int errCount = 0;
    int totalChecks = 0;
    always #12.5 mclk = ~mclk;
    csc_top csc_top_inst (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stopExec(stopExec), .haltExec(haltExec), .wakeReq(wakeReq),
        .lsStoppableOpt(lsOpt), .wdtEnableOpt(wdtOpt), .hsOscEn(hsOscEn), .x1OscEn(x1OscEn),
        .extClkEn(extClkEn), .lsOscEn(lsOscEn), .wdtClkEn(wdtClkEn),
        .cpuClkHigh(cpuClkHigh), .periphSel(periphSel), .stopMode(stopMode),
        .haltMode(haltMode));
    task stopTest;
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stopTest
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            errCount++;
        end
    endtask : chk
    // Master waits for pready rather than assuming zero wait states
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rv, ev);
    endtask : wr
    task rd(input logic [11:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r, ev);
    endtask : rd
    task pollBit(input logic [11:0] a, input int b, input int lim);
        int k;
        logic [31:0] r;
        k = 0;
        r = 32'h0;
        while (r[b] !== 1'b1 && k < lim) begin
            rd(a, r);
            k++;
        end
        chk("poll bit", 32'h1, {31'h0, r[b]});
    endtask : pollBit
    task waitCpu(input logic v);
        int k;
        k = 0;
        while (cpuClkHigh !== v && k < 40) begin
            @(posedge mclk);
            k++;
        end
        chk("cpuClkHigh", {31'h0, v}, {31'h0, cpuClkHigh});
    endtask : waitCpu
    task pulse(input int which);
        @(posedge mclk);
        if (which == 0) haltExec <= 1'b1; else if (which == 1) stopExec <= 1'b1;
        else wakeReq <= 1'b1;
        @(posedge mclk);
        haltExec <= 1'b0;
        stopExec <= 1'b0;
        wakeReq <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : pulse
    function automatic logic [1:0] expPeriph(input logic en, input logic ext);
        return !en ? PERIPH_INT : (ext ? PERIPH_EXT : PERIPH_X1);
    endfunction : expPeriph
    initial begin
        #(25 * 40000);
        errCount++;
        stopTest();
    end
    initial begin
        logic [31:0] r, d;
        logic [11:0] bad;
        nrst <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        stopExec <= 1'b0;
        haltExec <= 1'b0;
        wakeReq <= 1'b0;
        lsOpt <= 1'b1;
        wdtOpt <= 1'b1;
        void'($urandom(32'h590E65D1));
        for (int ext = 0; ext < 2; ext++) begin
            @(posedge mclk);
            nrst <= 1'b0;
            lsOpt <= 1'b1;
            wdtOpt <= 1'($urandom);
            repeat (8) @(posedge mclk);
            nrst <= 1'b1;
            repeat (5) @(posedge mclk);
            chk("hsOscEn", 32'h1, {31'h0, hsOscEn});
            chk("cpuClkHigh", 32'h0, {31'h0, cpuClkHigh});
            chk("periphSel", 32'h0, {30'h0, periphSel});
            chk("lsOscEn", 32'h1, {31'h0, lsOscEn});
            chk("wdtClkEn", {31'h0, wdtOpt}, {31'h0, wdtClkEn});
            rd(MAIN_MODE_OFF, r);
            chk("mode reg", 32'h0, r);
            rd(PIN_CTRL_OFF, r);
            chk("pin reg", 32'h0, r);
            rd(MAIN_OSC_OFF, r);
            chk("main stop reg", 32'h80, r);
            rd(SETTLE_SEL_OFF, r);
            chk("settle sel reset", 32'h4, r);
            pollBit(INT_MODE_OFF, INT_STABLE_BIT, 60);
            bad = 12'h018 + 12'(($urandom % 12'h3F9) * 4);
            d = $urandom;
            apb(1'b1, bad, d, r, ev);
            chk("unmapped err", 32'h1, {31'h0, ev});
            apb(1'b0, bad, 32'h0, r, ev);
            chk("unmapped data", 32'h0, r);
            wr(SETTLE_SEL_OFF, d);
            rd(SETTLE_SEL_OFF, r);
            chk("settle sel", {29'h0, d[2:0]}, r);
            wr(SETTLE_SEL_OFF, 32'h0);
            $display("test reset and map done pass %0d", ext);
            wr(INT_MODE_OFF, 32'h2);
            repeat (4) @(posedge mclk);
            chk("lsOscEn stop", 32'h0, {31'h0, lsOscEn});
            chk("wdtClkEn stop", 32'h0, {31'h0, wdtClkEn});
            chk("cpu not low speed", 32'h0, {31'h0, cpuClkHigh});
            wr(INT_MODE_OFF, 32'h0);
            repeat (4) @(posedge mclk);
            chk("lsOscEn restart", 32'h1, {31'h0, lsOscEn});
            lsOpt <= 1'b0;
            repeat (4) @(posedge mclk);
            wr(INT_MODE_OFF, 32'h2);
            repeat (4) @(posedge mclk);
            chk("lsOscEn locked", 32'h1, {31'h0, lsOscEn});
            wr(INT_MODE_OFF, 32'h0);
            $display("test low speed done pass %0d", ext);
            wr(PIN_CTRL_OFF, {24'h0, 1'(ext), 7'h40});
            wr(MAIN_OSC_OFF, 32'h0);
            wr(MAIN_MODE_OFF, 32'h4);
            repeat (4) @(posedge mclk);
            chk("periph split", {30'h0, expPeriph(1'b1, 1'(ext))}, {30'h0, periphSel});
            chk("x1 enable", {31'h0, 1'(ext == 0)}, {31'h0, x1OscEn});
            chk("ext enable", {31'h0, 1'(ext)}, {31'h0, extClkEn});
            if (ext == 0) pollBit(SETTLE_CNT_OFF, SETTLE_BASE, 200);
            wr(MAIN_MODE_OFF, 32'h5);
            @(posedge mclk);
            chk("status not early", 32'h0, {31'h0, cpuClkHigh});
            waitCpu(1'b1);
            rd(MAIN_MODE_OFF, r);
            chk("mode reg high", 32'h7, r);
            wr(MAIN_MODE_OFF, 32'h1);
            rd(MAIN_MODE_OFF, r);
            chk("enable locked", 32'h7, r);
            chk("periph high", {30'h0, expPeriph(1'b1, 1'(ext))}, {30'h0, periphSel});
            wr(INT_MODE_OFF, 32'h1);
            repeat (4) @(posedge mclk);
            chk("hsOscEn off", 32'h0, {31'h0, hsOscEn});
            pulse(0);
            chk("halt on high", 32'h1, {31'h0, haltMode});
            pulse(2);
            chk("halt left", 32'h0, {31'h0, haltMode});
            // STOP on the high-speed clock: X1 must settle again after release
            wr(SETTLE_SEL_OFF, 32'h0);
            pulse(1);
            chk("stop on high", 32'h1, {31'h0, stopMode});
            chk("stop main off", 32'h0, {31'h0, x1OscEn | extClkEn});
            pulse(2);
            chk("wake status high", 32'h1, {31'h0, cpuClkHigh});
            if (ext == 0) pollBit(SETTLE_CNT_OFF, SETTLE_BASE, 200);
            pulse(0);
            chk("halt after wake", 32'h1, {31'h0, haltMode});
            pulse(2);
            wr(INT_MODE_OFF, 32'h0);
            pollBit(INT_MODE_OFF, INT_STABLE_BIT, 60);
            wr(MAIN_MODE_OFF, 32'h4);
            waitCpu(1'b0);
            pulse(0);
            chk("halt on internal", 32'h1, {31'h0, haltMode});
            pulse(2);
            pulse(1);
            chk("stop mode", 32'h1, {31'h0, stopMode});
            chk("stop hs off", 32'h0, {31'h0, hsOscEn});
            pulse(2);
            chk("stop left", 32'h0, {31'h0, stopMode});
            $display("test switchover and standby done pass %0d", ext);
        end
        stopTest();
    end
endmodule : csc_top_bench
`default_nettype wire
